// >>> verilog/sie_regs.svh
`ifndef SIE_REGS_SVH
`define SIE_REGS_SVH
// i/o offsets of the stack pointer bytes
`define SIE_SP_LOW_OFS 6'h3d
`define SIE_SP_HIGH_OFS 6'h3e
// default last sram address (top of data space)
`define SIE_LAST_SRAM 16'h04ff
// cycle counts of entry and return
`define SIE_ENTRY_CYC 3'h4
`define SIE_RETURN_CYC 3'h4
`define SIE_SLEEP_EXTRA 3'h4
// byte steps of the stack pointer
`define SIE_STEP_BYTE 16'h0001
`define SIE_STEP_ADDR 16'h0002
// first interrupt vector sits past the reset slot
`define SIE_VEC_FIRST 16'h0002
`endif

// >>> verilog/sie_pkg.sv
package sie_pkg;
  // stack operation requested by the sequencer
  typedef enum logic [2:0] {
    SIE_STK_NONE = 3'h0,
    SIE_STK_PUSH = 3'h1,
    SIE_STK_POP = 3'h2,
    SIE_STK_CALL = 3'h3,
    SIE_STK_RET = 3'h4
  } sie_stk_op_t;
  // pointer pair addressing modes
  typedef enum logic [1:0] {
    SIE_PTR_PLAIN = 2'h0,
    SIE_PTR_DISP = 2'h1,
    SIE_PTR_POSTINC = 2'h2,
    SIE_PTR_PREDEC = 2'h3
  } sie_ptr_mode_t;
  // interrupt entry/return sequencer states
  typedef enum logic [3:0] {
    SIE_ST_RUN = 4'b0001,
    SIE_ST_ENTRY = 4'b0010,
    SIE_ST_RETURN = 4'b0100,
    SIE_ST_HOLD = 4'b1000
  } sie_state_t;
endpackage

// >>> verilog/sie_ptr_unit.sv
`timescale 1ns/100ps
`include "sie_regs.svh"
// pointer pair address generation
module sie_ptr_unit
  import sie_pkg::*;
(
  input wire logic [15:0] i_ptr,
  input wire sie_ptr_mode_t i_mode,
  input wire logic [5:0] i_disp,
  output logic [15:0] o_addr,
  output logic [15:0] o_ptr_next
);
  // address used and pointer written back per mode
  always_comb begin
    o_addr = i_ptr;
    o_ptr_next = i_ptr;
    case (i_mode)
      SIE_PTR_DISP: o_addr = i_ptr + {10'h000, i_disp};
      SIE_PTR_POSTINC: o_ptr_next = i_ptr + `SIE_STEP_BYTE;
      SIE_PTR_PREDEC: begin
        o_addr = i_ptr - `SIE_STEP_BYTE;
        o_ptr_next = i_ptr - `SIE_STEP_BYTE;
      end
      default: o_addr = i_ptr;
    endcase
  end
endmodule

// >>> verilog/sie_prio_enc.sv
`timescale 1ns/100ps
// lowest index wins; index 0 is the lowest vector
module sie_prio_enc #(
  parameter int N = 8,
  parameter int W = 3
) (
  input wire logic [N-1:0] i_req,
  output logic o_any,
  output logic [W-1:0] o_idx
);
  logic [N-1:0] hit;
  logic [N-1:0] lower;
  // the index must be wide enough for every request
  if (N < 2 || (1 << W) < N) begin : g_bad_param
    $error("sie_prio_enc: unsupported parameters");
  end
  // one-hot of the lowest set request
  genvar g;
  generate
    for (g = 0; g < N; g++) begin : g_pri
      if (g == 0) begin : g_first
        assign lower[g] = 1'b0;
      end else begin : g_rest
        assign lower[g] = lower[g-1] | i_req[g-1];
      end
      assign hit[g] = i_req[g] & ~lower[g];
    end
  endgenerate
  // encode the one-hot winner
  always_comb begin
    o_idx = '0;
    for (int k = 0; k < N; k++) begin
      if (hit[k]) begin
        o_idx = W'(k);
      end
    end
  end
  assign o_any = |i_req;
endmodule

// >>> verilog/sie_core.sv
`timescale 1ns/100ps
`include "sie_regs.svh"
// Notes on behaviour
// - upper six registers form three pointers
// - pointers: displacement, post-increment, pre-decrement
// - stack grows down; byte push minus one
// - calls and interrupt entry subtract two
// - byte pop returns data, plus one
// - returns pop address, add two
// - reset loads last sram address
// - stack pointer bytes at 0x3d, 0x3e
// - single undivided core clock
// - register alu op in one cycle
// - separate vectors; own and global enable
// - boot lock may mask interrupts
// - lower vector wins; reset highest
// - relocation bit, boot fuse move vectors
// - entry clears global enable
// - interrupt return sets global enable
// - vectoring or writing one clears flag
// - disabled flags held, served by priority
// - level requests only while present
// - one instruction after interrupt return
// - disable instruction blocks same cycle
// - one instruction after enable instruction
// - entry takes four cycles, sleep four more
// - multi-cycle instruction finishes first
// - return takes four cycles
module sie_core
  import sie_pkg::*;
#(
  parameter int NSRC = 8,
  parameter int SPW = 11,
  parameter int PCW = 13,
  parameter logic [15:0] LAST_SRAM = `SIE_LAST_SRAM,
  parameter logic [PCW-1:0] BOOT_START = '0
) (
  input wire logic i_mclk,
  input wire logic i_rst,
  // i/o register port
  input wire logic [5:0] i_io_addr,
  input wire logic i_io_wr,
  input wire logic [7:0] i_io_wdata,
  output logic [7:0] o_io_rdata,
  // sequencer side
  input wire logic i_boundary,
  input wire logic i_asleep,
  input wire sie_stk_op_t i_stk_op,
  input wire logic [PCW-1:0] i_pc,
  input wire logic i_set_gie,
  input wire logic i_clr_gie,
  input wire logic i_leave_interrupt_handler,
  input wire logic [7:0] i_flags_wdata,
  input wire logic i_flags_wr,
  output logic o_gie,
  output logic o_take,
  output logic o_busy,
  output logic [PCW-1:0] o_vector,
  output logic [15:0] o_stk_addr,
  output logic [15:0] o_sp,
  // pointer pairs
  input wire logic [1:0] i_ptr_sel,
  input wire sie_ptr_mode_t i_ptr_mode,
  input wire logic [5:0] i_ptr_disp,
  input wire logic i_ptr_use,
  input wire logic [47:0] i_ptr_pairs,
  output logic [15:0] o_ptr_addr,
  output logic [15:0] o_ptr_wb,
  output logic o_ptr_wb_en,
  // sources
  input wire logic [NSRC-1:0] i_evt,
  input wire logic [NSRC-1:0] i_level_type,
  input wire logic [NSRC-1:0] i_level,
  input wire logic [NSRC-1:0] i_src_en,
  input wire logic i_flag_clr_wr,
  input wire logic [NSRC-1:0] i_flag_clr,
  output logic [NSRC-1:0] o_flags,
  // boot configuration
  input wire logic i_relocate,
  input wire logic i_boot_reset_fuse,
  input wire logic i_boot_lock_a,
  input wire logic i_boot_lock_b,
  input wire logic i_pc_in_boot
);
  localparam int IW = $clog2(NSRC);
  // refuse sizes the pointer and vector logic cannot hold
  if (NSRC < 2 || SPW < 9 || SPW > 16 || PCW < IW + 2) begin : g_bad_param
    $error("sie_core: unsupported parameters");
  end
  logic [SPW-1:0] sp_ff, nxt_sp;
  logic gie_ff, nxt_gie;
  logic [NSRC-1:0] flag_ff;
  sie_state_t st_ff, nxt_st;
  logic [2:0] cnt_ff;
  logic [IW-1:0] sel_ff;
  logic hold_ff;
  logic [NSRC-1:0] pend;
  logic any_pend;
  logic [IW-1:0] win;
  logic [15:0] ptr_sel_val;
  logic allow;
  logic take;
  logic [PCW-1:0] vec_base;
  logic [7:0] rdata;

  // one undivided clock
  // all state runs on i_mclk; no divider or enable is applied
  // pointer pairs select
  always_comb begin
    case (i_ptr_sel)
      2'h0: ptr_sel_val = i_ptr_pairs[15:0];
      2'h1: ptr_sel_val = i_ptr_pairs[31:16];
      default: ptr_sel_val = i_ptr_pairs[47:32];
    endcase
  end
  sie_ptr_unit u_ptr (
    .i_ptr(ptr_sel_val),
    .i_mode(i_ptr_mode),
    .i_disp(i_ptr_disp),
    .o_addr(o_ptr_addr),
    .o_ptr_next(o_ptr_wb)
  );
  assign o_ptr_wb_en = i_ptr_use && (i_ptr_mode == SIE_PTR_POSTINC ||
    i_ptr_mode == SIE_PTR_PREDEC);

  assign pend = (flag_ff & ~i_level_type | i_level & i_level_type) &
    i_src_en;
  sie_prio_enc #(.N(NSRC), .W(IW)) u_prio (
    .i_req(pend),
    .o_any(any_pend),
    .o_idx(win)
  );
  assign allow = gie_ff && !i_clr_gie && i_boundary && !hold_ff &&
    !((i_boot_lock_a || i_boot_lock_b) && !i_pc_in_boot);
  assign take = allow && any_pend && st_ff == SIE_ST_RUN;
  assign o_take = take;
  assign o_busy = st_ff != SIE_ST_RUN;

  // entry/return sequencer
  always_comb begin
    nxt_st = st_ff;
    case (st_ff)
      SIE_ST_RUN: begin
        if (take) begin
          nxt_st = SIE_ST_ENTRY;
        end else if (i_leave_interrupt_handler && i_boundary) begin
          nxt_st = SIE_ST_RETURN;
        end
      end
      SIE_ST_ENTRY: if (cnt_ff == 3'h1) nxt_st = SIE_ST_RUN;
      SIE_ST_RETURN: if (cnt_ff == 3'h1) nxt_st = SIE_ST_HOLD;
      SIE_ST_HOLD: nxt_st = SIE_ST_RUN;
      default: nxt_st = SIE_ST_RUN;
    endcase
  end
  always_ff @(posedge i_mclk) begin
    if (i_rst) begin
      st_ff <= SIE_ST_RUN;
    end else begin
      st_ff <= nxt_st;
    end
  end
  // cycle counter of entry and return
  always_ff @(posedge i_mclk) begin
    if (i_rst) begin
      cnt_ff <= 3'h0;
    end else if (take) begin
      // sleep adds four
      // the take cycle counts as the first one, so load one short
      cnt_ff <= i_asleep ?
        3'(4'(`SIE_ENTRY_CYC) + 4'(`SIE_SLEEP_EXTRA) - 4'h1) :
        `SIE_ENTRY_CYC - 3'h1;
    end else if (st_ff == SIE_ST_RUN && i_leave_interrupt_handler && i_boundary) begin
      cnt_ff <= `SIE_RETURN_CYC - 3'h1;
    end else if (cnt_ff != 3'h0) begin
      cnt_ff <= cnt_ff - 3'h1;
    end
  end
  // winner latched at entry; others remain pending
  always_ff @(posedge i_mclk) begin
    if (i_rst) begin
      sel_ff <= '0;
    end else if (take) begin
      sel_ff <= win;
    end
  end
  // one after enable
  // hold until the next instruction boundary passes
  // a software write of the enable bit does not hold, only the instruction
  always_ff @(posedge i_mclk) begin
    if (i_rst) begin
      hold_ff <= 1'b0;
    end else if (st_ff == SIE_ST_HOLD || (i_set_gie && !gie_ff)) begin
      hold_ff <= 1'b1;
    end else if (i_boundary) begin
      hold_ff <= 1'b0;
    end
  end

  // global enable flag
  always_comb begin
    nxt_gie = gie_ff;
    if (i_flags_wr) begin
      nxt_gie = i_flags_wdata[7];
    end
    if (i_set_gie) begin
      nxt_gie = 1'b1;
    end
    if (i_clr_gie) begin
      nxt_gie = 1'b0;
    end
    if (st_ff == SIE_ST_RETURN && cnt_ff == 3'h1) begin
      nxt_gie = 1'b1;
    end
    if (take) begin
      nxt_gie = 1'b0;
    end
  end
  always_ff @(posedge i_mclk) begin
    if (i_rst) begin
      gie_ff <= 1'b0;
    end else begin
      gie_ff <= nxt_gie;
    end
  end
  assign o_gie = gie_ff;

  // event flags; a new event beats any clear
  genvar g;
  generate
    for (g = 0; g < NSRC; g++) begin : g_flag
      always_ff @(posedge i_mclk) begin
        if (i_rst) begin
          flag_ff[g] <= 1'b0;
        end else if (i_evt[g]) begin
          flag_ff[g] <= 1'b1;
        end else if ((take && win == IW'(g)) ||
          (i_flag_clr_wr && i_flag_clr[g])) begin
          flag_ff[g] <= 1'b0;
        end
      end
    end
  endgenerate
  assign o_flags = flag_ff;

  assign vec_base = i_relocate ? BOOT_START : '0;
  always_ff @(posedge i_mclk) begin
    if (i_rst) begin
      o_vector <= '0;
    end else if (take) begin
      // vector per source, after reset slot
      o_vector <= vec_base + PCW'({win, 1'b0}) + PCW'(`SIE_VEC_FIRST);
    end else if (st_ff == SIE_ST_RUN && i_boundary && !take) begin
      o_vector <= i_boot_reset_fuse ? BOOT_START : '0;
    end
  end

  // stack pointer next value
  always_comb begin
    nxt_sp = sp_ff;
    o_stk_addr = 16'(sp_ff);
    case (i_stk_op)
      SIE_STK_PUSH: nxt_sp = sp_ff - SPW'(`SIE_STEP_BYTE);
      SIE_STK_CALL: nxt_sp = sp_ff - SPW'(`SIE_STEP_ADDR);
      SIE_STK_POP: begin
        nxt_sp = sp_ff + SPW'(`SIE_STEP_BYTE);
        o_stk_addr = 16'(nxt_sp);
      end
      SIE_STK_RET: nxt_sp = sp_ff + SPW'(`SIE_STEP_ADDR);
      default: nxt_sp = sp_ff;
    endcase
    // interrupt return pops pc
    // the sequencer sends no stack op with the return
    if (st_ff == SIE_ST_RUN && i_leave_interrupt_handler && i_boundary && !take) begin
      nxt_sp = sp_ff + SPW'(`SIE_STEP_ADDR);
    end
    if (take) begin
      nxt_sp = sp_ff - SPW'(`SIE_STEP_ADDR);
    end
    if (i_io_wr && i_io_addr == `SIE_SP_LOW_OFS) begin
      nxt_sp[7:0] = i_io_wdata;
    end
    if (i_io_wr && i_io_addr == `SIE_SP_HIGH_OFS && SPW > 8) begin
      nxt_sp[SPW-1:8] = i_io_wdata[SPW-9:0];
    end
  end
  always_ff @(posedge i_mclk) begin
    if (i_rst) begin
      sp_ff <= LAST_SRAM[SPW-1:0];
    end else begin
      sp_ff <= nxt_sp;
    end
  end
  assign o_sp = 16'(sp_ff);

  // register read data, registered
  always_comb begin
    rdata = 8'h00;
    if (i_io_addr == `SIE_SP_LOW_OFS) begin
      rdata = o_sp[7:0];
    end else if (i_io_addr == `SIE_SP_HIGH_OFS) begin
      rdata = o_sp[15:8];
    end
  end
  always_ff @(posedge i_mclk) begin
    if (i_rst) begin
      o_io_rdata <= 8'h00;
    end else begin
      o_io_rdata <= rdata;
    end
  end
  // flags register not saved here
  // entry and return never touch the status flags beyond the enable bit
endmodule

// >>> verification/sie_core_assertions.sv
`timescale 1ns/100ps
// protocol checks on the stack and entry ports
module sie_core_assertions
  import sie_pkg::*;
#(
  parameter int SPW = 11
) (
  input wire logic i_mclk,
  input wire logic i_rst,
  input wire logic [5:0] i_io_addr,
  input wire sie_stk_op_t i_stk_op,
  input wire logic i_asleep,
  input wire logic i_clr_gie,
  input wire logic i_set_gie,
  input wire logic i_leave_interrupt_handler,
  input wire logic i_boundary,
  input wire logic o_take,
  input wire logic o_busy,
  input wire logic o_gie,
  input wire logic [7:0] o_io_rdata,
  input wire logic [15:0] o_sp
);
  default clocking cb @(posedge i_mclk); endclocking
  default disable iff (i_rst);
  // entry sequence steps
  sequence s_awake_take;
    o_take && !i_asleep;
  endsequence
  // busy for the cycles after the take cycle
  sequence s_entry_run;
    o_busy [*3];
  endsequence
  sequence s_sleep_take;
    o_take && i_asleep;
  endsequence
  sequence s_sleep_run;
    o_busy [*7];
  endsequence
  // stack op applied outside entry and return
  property p_sp(sie_stk_op_t op, int d);
    i_stk_op == op && !o_busy && !o_take
      |=> o_sp == 16'($past(o_sp) + d);
  endproperty
  property p_push; p_sp(SIE_STK_PUSH, -1); endproperty
  property p_pop; p_sp(SIE_STK_POP, 1); endproperty
  property p_call; p_sp(SIE_STK_CALL, -2); endproperty
  property p_ret; p_sp(SIE_STK_RET, 2); endproperty
  property p_entry_sp; o_take |=> o_sp == 16'($past(o_sp) - 2); endproperty
  property p_entry_gie; o_take |=> !o_gie; endproperty
  property p_entry_busy; s_awake_take |=> s_entry_run; endproperty
  property p_entry_sleep; s_sleep_take |=> s_sleep_run; endproperty
  property p_leave_interrupt_handler_sp;
    i_leave_interrupt_handler && i_boundary && !o_busy && !o_take
      |=> o_sp == 16'($past(o_sp) + 2);
  endproperty
  property p_cli; i_clr_gie |-> !o_take; endproperty
  property p_sei; i_set_gie |=> !o_take; endproperty
  property p_leave_interrupt_handler; i_leave_interrupt_handler && !o_busy |-> ##[1:8] o_gie; endproperty
  property p_rdata;
    !(i_io_addr inside {6'h3d, 6'h3e}) |=> o_io_rdata == 8'h00;
  endproperty
  property p_sp_top; (o_sp >> SPW) == 16'h0000; endproperty
  a_push: assert property (p_push)
    else $error("push step wrong");
  a_pop: assert property (p_pop)
    else $error("pop step wrong");
  a_call: assert property (p_call)
    else $error("call step wrong");
  a_ret: assert property (p_ret)
    else $error("return step wrong");
  a_entry_sp: assert property (p_entry_sp)
    else $error("entry step wrong");
  a_entry_gie: assert property (p_entry_gie)
    else $error("enable kept on entry");
  a_entry_busy: assert property (p_entry_busy)
    else $error("entry too short");
  a_entry_sleep: assert property (p_entry_sleep)
    else $error("sleep entry too short");
  a_leave_interrupt_handler_sp: assert property (p_leave_interrupt_handler_sp)
    else $error("interrupt return step wrong");
  a_cli: assert property (p_cli)
    else $error("take beside disable");
  a_sei: assert property (p_sei)
    else $error("take right after enable");
  a_leave_interrupt_handler: assert property (p_leave_interrupt_handler)
    else $error("enable not restored");
  a_rdata: assert property (p_rdata)
    else $error("unmapped read not zero");
  a_sp_top: assert property (p_sp_top)
    else $error("unused pointer bits set");
endmodule
bind sie_core sie_core_assertions #(.SPW(SPW)) sie_core_assertions_inst (
  .i_mclk(i_mclk), .i_rst(i_rst), .i_io_addr(i_io_addr),
  .i_stk_op(i_stk_op), .i_asleep(i_asleep), .i_clr_gie(i_clr_gie),
  .i_set_gie(i_set_gie), .i_leave_interrupt_handler(i_leave_interrupt_handler), .i_boundary(i_boundary),
  .o_take(o_take), .o_busy(o_busy), .o_gie(o_gie),
  .o_io_rdata(o_io_rdata), .o_sp(o_sp)
);

// >>> verification/sie_src_model.sv
`timescale 1ns/100ps
// peripheral sources: registered one-cycle event pulses
module sie_src_model (
  input wire logic i_mclk,
  input wire logic [7:0] i_hit,
  output logic [7:0] o_evt
);
  // registered so pulses leave just after the edge
  always_ff @(posedge i_mclk) begin
    o_evt <= i_hit;
  end
endmodule

// >>> verification/stack_and_interrupt_entry_bench.sv
`timescale 1ns/100ps
module stack_and_interrupt_entry_bench;
  import sie_pkg::*;
  logic i_mclk = 0, i_rst = 1, i_io_wr = 0, i_boundary = 0, i_asleep = 0;
  logic i_set_gie = 0, i_clr_gie = 0, i_leave_interrupt_handler = 0, i_flags_wr = 0;
  logic i_ptr_use = 0, i_flag_clr_wr = 0, i_relocate = 0, i_pc_in_boot = 0;
  logic i_boot_reset_fuse = 0, i_boot_lock_a = 0, i_boot_lock_b = 0;
  logic [5:0] i_io_addr = '0, i_ptr_disp = '0;
  logic [7:0] i_io_wdata = '0, i_flags_wdata = '0, hit = '0, i_src_en = '0;
  logic [7:0] i_level_type = '0, i_level = '0, i_flag_clr = '0, i_evt;
  logic [12:0] i_pc = '0, o_vector;
  logic [1:0] i_ptr_sel = '0;
  logic [47:0] i_ptr_pairs = '0;
  sie_stk_op_t i_stk_op = SIE_STK_NONE;
  sie_ptr_mode_t i_ptr_mode = SIE_PTR_PLAIN;
  logic [7:0] o_io_rdata, o_flags;
  logic o_gie, o_take, o_busy, o_ptr_wb_en;
  logic [15:0] o_stk_addr, o_sp, o_ptr_addr, o_ptr_wb;
  int error_cnt = 0, n_checks = 0;
  sie_core #(.BOOT_START(13'h1000)) sie_core_inst (
    .i_mclk(i_mclk), .i_rst(i_rst), .i_io_addr(i_io_addr),
    .i_io_wr(i_io_wr), .i_io_wdata(i_io_wdata), .o_io_rdata(o_io_rdata),
    .i_boundary(i_boundary), .i_asleep(i_asleep), .i_stk_op(i_stk_op),
    .i_pc(i_pc), .i_set_gie(i_set_gie), .i_clr_gie(i_clr_gie),
    .i_leave_interrupt_handler(i_leave_interrupt_handler), .i_flags_wdata(i_flags_wdata),
    .i_flags_wr(i_flags_wr), .o_gie(o_gie), .o_take(o_take),
    .o_busy(o_busy), .o_vector(o_vector), .o_stk_addr(o_stk_addr),
    .o_sp(o_sp), .i_ptr_sel(i_ptr_sel), .i_ptr_mode(i_ptr_mode),
    .i_ptr_disp(i_ptr_disp), .i_ptr_use(i_ptr_use),
    .i_ptr_pairs(i_ptr_pairs), .o_ptr_addr(o_ptr_addr),
    .o_ptr_wb(o_ptr_wb), .o_ptr_wb_en(o_ptr_wb_en), .i_evt(i_evt),
    .i_level_type(i_level_type), .i_level(i_level),
    .i_src_en(i_src_en), .i_flag_clr_wr(i_flag_clr_wr),
    .i_flag_clr(i_flag_clr), .o_flags(o_flags),
    .i_relocate(i_relocate), .i_boot_reset_fuse(i_boot_reset_fuse),
    .i_boot_lock_a(i_boot_lock_a), .i_boot_lock_b(i_boot_lock_b),
    .i_pc_in_boot(i_pc_in_boot)
  );
  sie_src_model sie_src_model_inst (
    .i_mclk(i_mclk), .i_hit(hit), .o_evt(i_evt)
  );
  // free-running core clock
  always #50 i_mclk = ~i_mclk;
  task test_done;
    if (error_cnt == 0 && n_checks > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask
  task automatic chk(input logic [15:0] g, input logic [15:0] e);
    n_checks++;
    if (g !== e) begin
      error_cnt++;
      $display("[ERR] %0t got %h want %h", $time, g, e);
    end
  endtask
  task cyc;
    @(posedge i_mclk);
  endtask
  task io(input logic [5:0] a, input logic w, input logic [7:0] d);
    cyc; i_io_addr <= a; i_io_wr <= w; i_io_wdata <= d;
    cyc; i_io_wr <= 0; #1;
  endtask
  task op(input sie_stk_op_t o, input logic [15:0] e,
    input logic [15:0] a);
    cyc; i_stk_op <= o; #1 chk(o_stk_addr, a);
    cyc; i_stk_op <= SIE_STK_NONE; #1 chk(o_sp, e);
  endtask
  task ev(input logic [7:0] m);
    cyc; hit <= m;
    cyc; hit <= '0;
    cyc;
  endtask
  // software enable through the flag register, gie bit 7
  // handler code restores the flag register itself
  task gie1;
    cyc; i_flags_wdata <= 8'h80; i_flags_wr <= 1;
    cyc; i_flags_wr <= 0;
  endtask
  task idle;
    #1;
    for (int k = 0; k < 12 && o_busy !== 1'b0; k++) begin cyc; #1; end
  endtask
  task tk(input logic [12:0] v);
    cyc; i_boundary <= 1; #1 chk(o_take, 1);
    cyc; i_boundary <= 0; #1 chk(o_vector, v);
    chk(o_gie, 0);
  endtask
  task t_regs;
    io(6'h3d, 1, 8'h80); io(6'h3e, 1, 8'hff); io(6'h3e, 0, 0);
    chk(o_io_rdata, 8'h07);
    io(6'h3d, 0, 0); chk(o_io_rdata, 8'h80);
    io(6'h3f, 0, 0); chk(o_io_rdata, 8'h00);
    io(6'h3e, 1, 8'h04); chk(o_sp, 16'h0480);
  endtask
  task t_irq;
    i_src_en <= 8'h2c;
    gie1; ev(8'h08); #1 chk(o_flags, 8'h08);
    tk(13'd8); chk(o_flags, 8'h00);
    chk(o_sp, 16'h047e); chk(o_busy, 1);
    ev(8'h08);
  endtask
  task t_leave_interrupt_handler;
    idle;
    cyc; i_leave_interrupt_handler <= 1; i_boundary <= 1;
    cyc; i_leave_interrupt_handler <= 0; #1;
    for (int k = 0; k < 8 && o_gie !== 1'b1; k++) begin cyc; #1; end
    chk(o_gie, 1); chk(o_take, 0);
    chk(o_sp, 16'h0480);
    cyc; #1 chk(o_take, 0);
    cyc; #1 chk(o_take, 1);
    cyc; i_boundary <= 0; #1 chk(o_vector, 13'd8);
  endtask
  task t_prio;
    idle; ev(8'h24); gie1;
    tk(13'd6); chk(o_flags, 8'h20);
  endtask
  task t_block;
    idle; gie1;
    cyc; i_boot_lock_a <= 1; i_boot_lock_b <= 1; i_boundary <= 1;
    #1 chk(o_take, 0);
    cyc; i_boot_lock_a <= 0; i_boot_lock_b <= 0; i_clr_gie <= 1;
    #1 chk(o_take, 0);
    cyc; i_clr_gie <= 0; i_boundary <= 0; i_flag_clr_wr <= 1;
    i_flag_clr <= 8'h20;
    cyc; i_flag_clr_wr <= 0; #1 chk(o_gie, 0);
    chk(o_flags, 8'h00);
  endtask
  task t_level;
    cyc; i_level_type <= 8'h02; i_level <= 8'h02;
    cyc; i_level <= '0;
    cyc; i_src_en <= 8'h2e; gie1;
    cyc; i_boundary <= 1; #1 chk(o_take, 0);
    cyc; i_boundary <= 0; i_level <= 8'h02;
    tk(13'd4);
  endtask
  task t_ptr;
    cyc; i_ptr_sel <= 2'd1; i_ptr_use <= 1; i_ptr_mode <= SIE_PTR_POSTINC;
    i_ptr_pairs <= {16'habcd, 16'h1234, 16'h5678};
    #1 chk(o_ptr_addr, 16'h1234); chk(o_ptr_wb, 16'h1235);
    chk(o_ptr_wb_en, 1);
    cyc; i_ptr_mode <= SIE_PTR_PREDEC; #1 chk(o_ptr_addr, 16'h1233);
    cyc; i_ptr_mode <= SIE_PTR_DISP; i_ptr_disp <= 6'h05;
    #1 chk(o_ptr_addr, 16'h1239);
    cyc; i_ptr_sel <= 2'd2; i_ptr_mode <= SIE_PTR_PLAIN;
    #1 chk(o_ptr_addr, 16'habcd); chk(o_ptr_wb_en, 0);
    cyc; i_ptr_sel <= 2'd0; #1 chk(o_ptr_addr, 16'h5678);
  endtask
  task t_boot;
    idle;
    cyc; i_level <= '0; i_relocate <= 1; i_asleep <= 1;
    i_boot_lock_a <= 1; i_pc_in_boot <= 1;
    ev(8'h04);
    cyc; i_set_gie <= 1; i_boundary <= 1;
    cyc; i_set_gie <= 0; #1 chk(o_take, 0);
    cyc; #1 chk(o_take, 1);
    cyc; i_boundary <= 0; #1 chk(o_vector, 13'h1006);
    chk(o_sp, 16'h0478);
    for (int k = 0; k < 6; k++) begin
      cyc; #1 chk(o_busy, 1);
    end
    cyc; #1 chk(o_busy, 0);
    cyc; i_boundary <= 1; i_boot_reset_fuse <= 1; i_relocate <= 0;
    i_asleep <= 0; i_boot_lock_a <= 0;
    cyc; i_boundary <= 0; #1 chk(o_vector, 13'h1000);
  endtask
  // main sequence
  initial begin
    repeat (12) cyc;
    i_rst <= 0;
    #1 chk(o_sp, 16'h04ff); chk(o_gie, 0);
    t_regs;
    op(SIE_STK_PUSH, 16'h047f, 16'h0480);
    op(SIE_STK_POP, 16'h0480, 16'h0480);
    op(SIE_STK_CALL, 16'h047e, 16'h0480);
    op(SIE_STK_RET, 16'h0480, 16'h047e);
    t_irq; t_leave_interrupt_handler; t_prio; t_block; t_level; t_ptr; t_boot;
    test_done;
  end
  // hang guard, far beyond the hundred or so cycles of the run
  initial begin
    repeat (3000) @(posedge i_mclk);
    error_cnt++;
    test_done;
  end
endmodule
